//--- logic/udpcfg_pkg.sv
// Constants, field positions and types for the upconverter data port configuration block
package udpcfg_pkg;
   // Register word addresses
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h01;
   localparam logic [7:0] ADDR_RATE = 8'h04;
   localparam logic [7:0] ADDR_FREQ = 8'h07;
   // Reset values
   localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL2_RESET = 32'h0040_0820;
   localparam logic [31:0] RATE_RESET = 32'h0FFF_FFFF;
   localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
   // First control function register fields
   localparam int MODE_LO = 24;
   localparam logic [1:0] MODE_QUAD = 2'b00;
   // Second control function register fields
   localparam int B_SERIAL_PORT = 31;
   localparam int B_INT_UPDATE = 23;
   localparam int B_SYNC_EN = 22;
   localparam int B_READ_EFF = 16;
   localparam int PRESC_LO = 14;
   localparam int B_PD_RATE = 13;
   localparam int B_FORMAT = 12;
   localparam int B_PD_EN = 11;
   localparam int B_PD_INV = 10;
   localparam int B_TX_INV = 9;
   // Data port timing: core cycles per data clock phase at full rate
   localparam logic [2:0] PD_PHASE_CYCLES = 3'h2;
   localparam int DATA_W = 18;

   typedef struct packed {
      logic [DATA_W-1:0] i;
      logic [DATA_W-1:0] q;
   } udpcfg_iq_t;
endpackage

//--- logic/udpcfg_buf2.sv
// Two-entry elastic buffer with registered outputs
module udpcfg_buf2
   import udpcfg_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire udpcfg_iq_t in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output udpcfg_iq_t out_data_o,
   input wire logic out_ready_i
);
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   udpcfg_iq_t tail_r;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = (count_r != 2'h2);
   assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         count_r <= 2'h0;
         out_valid_o <= 1'b0;
         out_data_o <= '0;
         tail_r <= '0;
      end else begin
         count_r <= count_nxt;
         out_valid_o <= (count_nxt != 2'h0);
         // Head always holds the oldest word so the output stays a flop
         if (pop && count_r == 2'h2) begin
            out_data_o <= tail_r;
         end else if (push && (count_r == 2'h0 || (pop && count_r == 2'h1))) begin
            out_data_o <= in_data_i;
         end
         if (push && count_r == 2'h1 && !pop) begin
            tail_r <= in_data_i;
         end
      end
   end

   a_buf_no_overfill: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (count_r == 2'h2 && !pop) |=> (count_r == 2'h2 && !in_ready_o))
      else $error("buffer count changed while full and not drained");
endmodule

//--- logic/udpcfg_top.sv
// Data port configuration bits, update strobe and parallel I/Q port assembler
// Overview of operation
// - Sync clock off is low, on is quarter rate
// - Frequency word read returns stored or effective value
// - Prescaler divides update timer by 1,2,4,8
// - Rate bit halves data clock in quadrature parallel
// - Format bit one means offset binary words
// - Data clock enable off forces pin low
// - Q pairs with high phase, invertible
// - Transmit gate polarity selectable by invert bit
// - Mode field 00 selects quadrature modulation
// - Bit 23 drives update pin, else input
// - Bit 31 zero selects 18-bit parallel port
module udpcfg_top
   import udpcfg_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Frequency word
   input wire logic [31:0] freq_accum_i,
   output logic [31:0] freq_word_o,
   // Sync clock and update pin
   output logic sync_clk_o,
   input wire logic io_update_i,
   output logic io_update_o,
   output logic io_update_oe_o,
   output logic update_strobe_o,
   // Parallel data port
   output logic parallel_port_o,
   output logic pd_clk_o,
   input wire logic [DATA_W-1:0] pdata_i,
   input wire logic transmit_gate_i,
   // Assembled I/Q pairs
   output logic iq_valid_o,
   output udpcfg_iq_t iq_o,
   input wire logic iq_ready_i
);
   // Offset binary differs from two's complement only in the sign bit
   function automatic logic [DATA_W-1:0] to_twos(input logic [DATA_W-1:0] w,
                                                input logic offset_bin);
      to_twos = {w[DATA_W-1] ^ offset_bin, w[DATA_W-2:0]};
   endfunction

   logic [31:0] ctrl1_r;
   logic [31:0] ctrl2_r;
   logic [31:0] rate_r;
   logic [1:0] sync_cnt_r;
   logic [2:0] presc_cnt_r;
   logic [31:0] upd_cnt_r;
   logic io_update_q_r;
   logic [2:0] pd_cnt_r;
   logic pd_phase_r;
   logic [DATA_W-1:0] i_hold_r;
   logic i_have_r;
   logic [31:0] rd_word;

   // Field decode
   wire [1:0] presc_sel = ctrl2_r[PRESC_LO+1:PRESC_LO];
   wire int_update = ctrl2_r[B_INT_UPDATE];
   wire quad_mode = (ctrl1_r[MODE_LO+1:MODE_LO] == MODE_QUAD);
   wire par_sel = !ctrl2_r[B_SERIAL_PORT];
   wire pd_half = ctrl2_r[B_PD_RATE] && quad_mode && par_sel;
   wire [2:0] phase_len = pd_half ? (PD_PHASE_CYCLES << 1) : PD_PHASE_CYCLES;
   wire fmt_offset = ctrl2_r[B_FORMAT];
   wire tx_active = transmit_gate_i ^ ctrl2_r[B_TX_INV];

   // Prescaler: mask of low counter bits that must all be set
   wire [2:0] presc_mask = {presc_sel == 2'b11, presc_sel[1], presc_sel != 2'b00};
   wire presc_tick = int_update && ((presc_cnt_r & presc_mask) == presc_mask);
   wire upd_fire = presc_tick && (upd_cnt_r >= rate_r);

   // Data clock sequencing; a full buffer freezes the clock to stall the source
   wire buf_ready;
   wire pd_tick = (pd_cnt_r >= phase_len - 3'h1);
   wire pd_adv = pd_tick && buf_ready;
   // Internal phase one is Q; invert moves only the pin, so Q follows the low pin
   wire word_is_q = pd_phase_r;
   wire [DATA_W-1:0] word_conv = to_twos(pdata_i, fmt_offset);
   wire pair_push = pd_adv && word_is_q && i_have_r && tx_active;
   wire pd_phase_nxt = pd_adv ? !pd_phase_r : pd_phase_r;
   udpcfg_iq_t pair_word;
   assign pair_word = '{i: i_hold_r, q: word_conv};

   // Read mux, unmapped words read as zero
   wire [31:0] freq_view = ctrl2_r[B_READ_EFF] ? freq_accum_i : freq_word_o;
   assign rd_word = (reg_addr_i == ADDR_CTRL1) ? ctrl1_r :
                    (reg_addr_i == ADDR_CTRL2) ? ctrl2_r :
                    (reg_addr_i == ADDR_RATE) ? rate_r :
                    (reg_addr_i == ADDR_FREQ) ? freq_view : 32'h0000_0000;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl1_r <= CTRL1_RESET;
         ctrl2_r <= CTRL2_RESET;
         rate_r <= RATE_RESET;
         freq_word_o <= FREQ_RESET;
         reg_rdata_o <= 32'h0000_0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         if (reg_wr_i && reg_addr_i == ADDR_CTRL1) ctrl1_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == ADDR_CTRL2) ctrl2_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == ADDR_RATE) rate_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == ADDR_FREQ) freq_word_o <= reg_wdata_i;
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) reg_rdata_o <= rd_word;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync_cnt_r <= 2'h0;
         sync_clk_o <= 1'b0;
         presc_cnt_r <= 3'h0;
         upd_cnt_r <= 32'h0000_0000;
         io_update_q_r <= 1'b0;
         io_update_o <= 1'b0;
         io_update_oe_o <= 1'b0;
         update_strobe_o <= 1'b0;
         parallel_port_o <= 1'b1;
      end else begin
         sync_cnt_r <= sync_cnt_r + 2'h1;
         sync_clk_o <= ctrl2_r[B_SYNC_EN] && sync_cnt_r[1];
         presc_cnt_r <= presc_cnt_r + 3'h1;
         if (!int_update || upd_fire) upd_cnt_r <= 32'h0000_0000;
         else if (presc_tick) upd_cnt_r <= upd_cnt_r + 32'h0000_0001;
         io_update_q_r <= io_update_i;
         io_update_oe_o <= int_update;
         io_update_o <= upd_fire;
         // Outside strobe is taken on its rising edge only in input mode
         update_strobe_o <= int_update ? upd_fire : (io_update_i && !io_update_q_r);
         parallel_port_o <= par_sel;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pd_cnt_r <= 3'h0;
         pd_phase_r <= 1'b0;
         pd_clk_o <= 1'b0;
         i_hold_r <= '0;
         i_have_r <= 1'b0;
      end else begin
         if (pd_adv) pd_cnt_r <= 3'h0;
         else if (!pd_tick) pd_cnt_r <= pd_cnt_r + 3'h1;
         pd_phase_r <= pd_phase_nxt;
         // Internal clock keeps running while the pin is held low
         pd_clk_o <= ctrl2_r[B_PD_EN] && (pd_phase_nxt ^ ctrl2_r[B_PD_INV]);
         if (pd_adv && !word_is_q) begin
            i_hold_r <= word_conv;
            i_have_r <= tx_active;
         end else if (pd_adv) begin
            i_have_r <= 1'b0;
         end
      end
   end

   udpcfg_buf2 u_buf (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(pair_push),
      .in_data_i(pair_word),
      .in_ready_o(buf_ready),
      .out_valid_o(iq_valid_o),
      .out_data_o(iq_o),
      .out_ready_i(iq_ready_i)
   );

   a_sync_off_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !ctrl2_r[B_SYNC_EN] |=> !sync_clk_o)
      else $error("sync clock not low while disabled");
   a_sync_quarter_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (ctrl2_r[B_SYNC_EN] && $rose(sync_clk_o)) ##1 ctrl2_r[B_SYNC_EN][*3] |=> $rose(sync_clk_o))
      else $error("sync clock period is not four cycles");
   a_freq_read_eff: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == ADDR_FREQ && ctrl2_r[B_READ_EFF])
      |=> (reg_rvalid_o && reg_rdata_o == $past(freq_accum_i)))
      else $error("effective frequency word not returned");
   a_freq_read_store: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == ADDR_FREQ && !ctrl2_r[B_READ_EFF])
      |=> (reg_rdata_o == $past(freq_word_o)))
      else $error("stored frequency word not returned");
   a_read_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered next cycle");
   a_presc_div_eight: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ((int_update && presc_sel == 2'b11)[*8] ##1 presc_tick) |-> $past(presc_tick, 8))
      else $error("prescale by eight spacing wrong");
   a_pd_clk_off_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !ctrl2_r[B_PD_EN] |=> !pd_clk_o)
      else $error("data clock pin not low while disabled");
   a_update_pin_dir: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ##1 (io_update_oe_o == $past(int_update)) && (!io_update_oe_o -> !io_update_o))
      else $error("update pin direction wrong");
   a_standby_no_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!tx_active && pd_adv && !word_is_q) |=> !pair_push)
      else $error("pair pushed after standby I word");
   a_port_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ##1 parallel_port_o == !$past(ctrl2_r[B_SERIAL_PORT]))
      else $error("parallel port select wrong");
   a_stall_freezes: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !buf_ready |=> $stable(pd_phase_r))
      else $error("data clock moved while buffer full");
   // Source sees its back-pressure only through a pin that stops moving
   a_stall_pin_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!buf_ready && $stable(ctrl2_r)) |=> $stable(pd_clk_o))
      else $error("data clock pin moved while buffer full");
   a_pair_reaches_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
      pair_push |=> iq_valid_o)
      else $error("pushed pair not offered");
   // Outside strobe only counts in input mode
   a_ext_strobe_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!int_update && io_update_i && !io_update_q_r) |=> update_strobe_o)
      else $error("outside update edge not passed on");
endmodule

//--- dv/udpcfg_source.sv
// Baseband source model driving the parallel I/Q port
module udpcfg_source
   import udpcfg_pkg::*;
(
   // Port clock and coding
   input wire logic core_clk_i,
   input wire logic pd_clk_i,
   input wire logic inv_i,
   input wire logic fmt_i,
   // Data bus
   output logic [DATA_W-1:0] pdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] word_r = '0;
   logic q_prev_r = 1'b0;
   logic q_phase;
   logic [DATA_W-1:0] raw;
   assign q_phase = pd_clk_i ^ inv_i;
   assign raw = q_phase ? word_r + 18'h0_0001 : word_r;
   // Next pair starts when the pin leaves the Q phase
   always @(negedge core_clk_i) begin
      q_prev_r <= q_phase;
      if (q_prev_r && !q_phase) begin
         word_r <= word_r + 18'h0_0002;
      end
      pdata_o <= fmt_i ? {~raw[DATA_W-1], raw[DATA_W-2:0]} : raw;
   end
endmodule

//--- dv/udpcfg_top_bench.sv
// Self-checking bench for the data port configuration block
module udpcfg_top_bench;
   import udpcfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] accum = 32'hCAFE_0123;
   logic [31:0] rdata, freq;
   logic rvalid, sync_clk, upd_out, upd_oe, upd_strobe, par_port, pd_clk, valid;
   logic upd_in = 1'b0;
   logic gate = 1'b1;
   logic ready = 1'b1;
   logic inv = 1'b0;
   logic fmt = 1'b0;
   logic mon = 1'b0;
   logic seq_ok = 1'b0;
   logic [DATA_W-1:0] pdata, prev_i;
   udpcfg_iq_t iq;
   int fail_count = 0;
   int cmp_count = 0;
   int n, p0, p;
   always #5 clk = ~clk;
   udpcfg_top u_dut (.core_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .freq_accum_i(accum), .freq_word_o(freq), .sync_clk_o(sync_clk), .io_update_i(upd_in),
      .io_update_o(upd_out), .io_update_oe_o(upd_oe), .update_strobe_o(upd_strobe),
      .parallel_port_o(par_port), .pd_clk_o(pd_clk), .pdata_i(pdata),
      .transmit_gate_i(gate), .iq_valid_o(valid), .iq_o(iq), .iq_ready_i(ready));
   udpcfg_source u_src (.core_clk_i(clk), .pd_clk_i(pd_clk), .inv_i(inv), .fmt_i(fmt),
      .pdata_o(pdata));
   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      check("rvalid", 36'(rvalid), 36'h1);
      check("rdata", 36'(rdata), 36'(exp));
   endtask
   // Pairing is only judged once the assembler has settled on a new setting
   task automatic settle;
      mon = 1'b0;
      repeat (16) @(negedge clk);
      seq_ok = 1'b0;
      mon = 1'b1;
      repeat (40) @(negedge clk);
   endtask
   task automatic upd_period(output int c);
      repeat (2) begin
         @(negedge clk);
         c = 1;
         while (upd_out !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
         end
      end
   endtask
   task automatic pd_high(output int c);
      c = 0;
      for (int k = 0; k < 20 && pd_clk !== 1'b0; k++) @(negedge clk);
      for (int k = 0; k < 20 && pd_clk !== 1'b1; k++) @(negedge clk);
      while (pd_clk === 1'b1 && c < 20) begin
         @(negedge clk);
         c++;
      end
   endtask
   always @(negedge clk) begin
      if (mon && valid === 1'b1 && ready) begin
         check("pair q", 36'(iq.q), 36'(iq.i + 18'h0_0001));
         if (seq_ok) check("pair i", 36'(iq.i), 36'(prev_i + 18'h0_0002));
         prev_i = iq.i;
         seq_ok = 1'b1;
      end
   end
   initial begin
      #100us;
      fail_count++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      check("parallel port", 36'(par_port), 36'h1);
      reg_rd(ADDR_CTRL2, CTRL2_RESET);
      reg_rd(ADDR_RATE, RATE_RESET);
      reg_rd(8'h09, 32'h0000_0000);
      for (int e = 1; e >= 0; e--) begin
         reg_wr(ADDR_CTRL2, 32'h0000_0820 | (32'(e) << B_SYNC_EN));
         n = 0;
         for (int k = 0; k < 8; k++) @(negedge clk) n += sync_clk;
         check("sync highs", 36'(n), 36'(4 * e));
      end
      reg_wr(ADDR_FREQ, 32'h1234_5678);
      reg_rd(ADDR_FREQ, 32'h1234_5678);
      check("freq word", 36'(freq), 36'h1234_5678);
      reg_wr(ADDR_CTRL2, 32'h0041_0820);
      reg_rd(ADDR_FREQ, accum);
      reg_wr(ADDR_RATE, 32'h0000_0002);
      for (int s = 0; s < 4; s++) begin
         reg_wr(ADDR_CTRL2, 32'h00C0_0820 | (32'(s) << PRESC_LO));
         upd_period(p);
         if (s == 0) p0 = p;
         check("update period", 36'(p), 36'(p0 << s));
         check("update oe", 36'(upd_oe), 36'h1);
      end
      reg_wr(ADDR_CTRL2, CTRL2_RESET);
      repeat (4) @(negedge clk);
      check("update oe", 36'(upd_oe), 36'h0);
      upd_in = 1'b1;
      for (n = 0; n < 4 && upd_strobe !== 1'b1; n++) @(negedge clk);
      check("ext strobe", 36'(upd_strobe), 36'h1);
      check("update out", 36'(upd_out), 36'h0);
      upd_in = 1'b0;
      settle();
      pd_high(n);
      check("data clk high", 36'(n), 36'(PD_PHASE_CYCLES));
      reg_wr(ADDR_CTRL2, 32'h0040_2820);
      pd_high(n);
      check("data clk half", 36'(n), 36'(2 * PD_PHASE_CYCLES));
      reg_wr(ADDR_CTRL1, 32'h0100_0000);
      pd_high(n);
      check("data clk mode", 36'(n), 36'(PD_PHASE_CYCLES));
      // Pairs formed while the coding changes are not judged
      mon = 1'b0;
      reg_wr(ADDR_CTRL1, 32'h0000_0000);
      reg_wr(ADDR_CTRL2, 32'h0040_1820);
      fmt = 1'b1;
      settle();
      mon = 1'b0;
      reg_wr(ADDR_CTRL2, 32'h0040_1C20);
      inv = 1'b1;
      settle();
      // Stalled consumer: buffer fills and the data clock must freeze
      ready = 1'b0;
      repeat (30) @(negedge clk);
      p = pd_clk;
      n = 0;
      for (int k = 0; k < 20; k++) @(negedge clk) n += (pd_clk !== p[0]) ? 1 : 0;
      check("data clk moves", 36'(n), 36'h0);
      repeat (10) @(negedge clk);
      check("data clk frozen", 36'(pd_clk), 36'(p));
      check("buffer valid", 36'(valid), 36'h1);
      ready = 1'b1;
      repeat (40) @(negedge clk);
      gate = 1'b0;
      repeat (30) @(negedge clk);
      check("standby", 36'(valid), 36'h0);
      mon = 1'b0;
      reg_wr(ADDR_CTRL2, 32'h0040_1E20);
      settle();
      check("gate swapped", 36'(seq_ok), 36'h1);
      mon = 1'b0;
      reg_wr(ADDR_CTRL2, 32'h0040_1620);
      n = 0;
      for (int k = 0; k < 20; k++) @(negedge clk) n += pd_clk;
      check("data clk off", 36'(n), 36'h0);
      for (n = 0; n < 20 && valid !== 1'b1; n++) @(negedge clk);
      check("assembler on", 36'(valid), 36'h1);
      conclude();
   end
endmodule
